// >>> hdl/timer_pkg.sv
// Shared constants and types of the dual timer block
package timer_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // ****************************************
  // Register indexes and byte addresses
  // ****************************************
  localparam logic [7:0] IDX_CONTROL    = 8'h88;
  localparam logic [7:0] IDX_MODE       = 8'h89;
  localparam logic [7:0] IDX_TL0        = 8'h8A;
  localparam logic [7:0] IDX_TL1        = 8'h8B;
  localparam logic [7:0] IDX_TH0        = 8'h8C;
  localparam logic [7:0] IDX_TH1        = 8'h8D;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h90;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h91;

  localparam logic [11:0] ADDR_CONTROL    = {2'h0, IDX_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_MODE       = {2'h0, IDX_MODE, 2'h0};
  localparam logic [11:0] ADDR_TL0        = {2'h0, IDX_TL0, 2'h0};
  localparam logic [11:0] ADDR_TL1        = {2'h0, IDX_TL1, 2'h0};
  localparam logic [11:0] ADDR_TH0        = {2'h0, IDX_TH0, 2'h0};
  localparam logic [11:0] ADDR_TH1        = {2'h0, IDX_TH1, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK   = {2'h0, IDX_IRQ_MASK, 2'h0};

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned CTL_OVF1 = 7;
  localparam int unsigned CTL_RUN1 = 6;
  localparam int unsigned CTL_OVF0 = 5;
  localparam int unsigned CTL_RUN0 = 4;
  localparam int unsigned UNIT1_PIN_GATING    = 7;
  localparam int unsigned SRC1     = 6;
  localparam int unsigned MODE1_HI = 5;
  localparam int unsigned MODE1_LO = 4;
  localparam int unsigned UNIT0_PIN_GATING    = 3;
  localparam int unsigned SRC0     = 2;
  localparam int unsigned MODE0_HI = 1;
  localparam int unsigned MODE0_LO = 0;

  localparam logic [7:0] BYTE_RESET    = 8'h00;
  localparam logic [7:0] BYTE_MAX      = 8'hFF;
  localparam logic [4:0] PRESCALE_MAX  = 5'h1F;

  typedef enum logic [1:0] {
    MODE_PRESCALED,
    MODE_CASCADED,
    MODE_RELOAD,
    MODE_SPLIT
  } mode_t;

endpackage

// >>> hdl/timer_pins_if.sv
// Conditioned external pins passed from the synchroniser to the timers
`timescale 1ns/10ps
`default_nettype none
interface timer_pins_if;
  logic [1:0] event_fall;
  logic [1:0] irq_level;
  modport conditioner (output event_fall, output irq_level);
  modport timer       (input event_fall, input irq_level);
endinterface
`default_nettype wire

// >>> hdl/pin_conditioner.sv
// Synchronises event and interrupt pins and finds event falling edges
`timescale 1ns/10ps
`default_nettype none
module pin_conditioner
  import timer_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [1:0]  event_pins,
  input  wire logic [1:0]  irq_pins,
  timer_pins_if.conditioner pins
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = {irq_pins, event_pins};
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // High sample then low sample
  // ****************************************
  genvar i;
  for (i = 0; i < 2; i++) begin : g_edge
    assign pins.event_fall[i] = s.s3[i] & ~s.s2[i];
  end
  assign pins.irq_level = s.s2[3:2];

  a_fall_one_cycle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pins.event_fall[0] |=> !pins.event_fall[0])
    else $error("event edge pulse lasted over one cycle");

endmodule
`default_nettype wire

// >>> hdl/timer_irq_events.sv
// Sticky overflow status, mask and interrupt level
`timescale 1ns/10ps
`default_nettype none
module timer_irq_events
  import timer_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] event_set,
  input  wire logic       wr_status,
  input  wire logic       wr_mask,
  input  wire logic [1:0] wdata,
  output logic      [1:0] status,
  output logic      [1:0] mask,
  output logic            timer_irq
);

  typedef struct packed {
    logic [1:0] status;
    logic [1:0] mask;
  } irq_state_t;

  irq_state_t s;
  irq_state_t next_s;

  // Write one clears, but a new event in the same cycle still lands
  always_comb begin
    next_s = s;
    if (wr_status) begin
      next_s.status = s.status & ~wdata;
    end
    if (wr_mask) begin
      next_s.mask = wdata;
    end
    next_s.status = next_s.status | event_set;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign status    = s.status;
  assign mask      = s.mask;
  assign timer_irq = |(s.status & s.mask);

  a_irq_follows_event: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (|(event_set & s.mask)) && !wr_mask |=> timer_irq)
    else $error("unmasked event did not raise the interrupt");

endmodule
`default_nettype wire

// >>> hdl/dual_timer_mode_control.sv
// Two 16-bit timer/counters with mode select and an APB register slave
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none

module dual_timer_mode_control
  import timer_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              unit0_event_pin,
  input  wire logic              unit1_event_pin,
  input  wire logic              ext_irq0_pin,
  input  wire logic              ext_irq1_pin,
  input  wire logic              unit0_vector_ack,
  input  wire logic              unit1_vector_ack,
  output logic                   unit0_overflow_flag,
  output logic                   unit1_overflow_flag,
  output logic                   timer_irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic              run1;
    logic              run0;
    logic              ovf1;
    logic              ovf0;
    logic [7:0]        mode_sel;
    logic [7:0]        tl0;
    logic [7:0]        th0;
    logic [7:0]        tl1;
    logic [7:0]        th1;
    logic [DATA_W-1:0] rdata;
  } core_state_t;

  core_state_t s;
  core_state_t next_s;

  timer_pins_if pins ();

  logic        unit0_pin_gating;
  logic        unit1_pin_gating;
  logic        src0;
  logic        src1;
  mode_t       mode0;
  mode_t       mode1;
  logic        split;
  logic        tick0;
  logic        tick1;
  logic        tick_h;
  logic [16:0] step0;
  logic [16:0] step1;
  logic        ovf_h;
  logic [1:0]  ovf_set;
  logic        setup;
  logic        wr;
  logic        hit;
  logic [7:0]  rd_byte;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;

  // ****************************************
  // Pins and interrupt helpers
  // ****************************************
  pin_conditioner i_pin_conditioner (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .event_pins ({unit1_event_pin, unit0_event_pin}),
    .irq_pins   ({ext_irq1_pin, ext_irq0_pin}),
    .pins       (pins.conditioner)
  );

  timer_irq_events i_timer_irq_events (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .event_set (ovf_set),
    .wr_status (wr && paddr == ADDR_IRQ_STATUS),
    .wr_mask   (wr && paddr == ADDR_IRQ_MASK),
    .wdata     (pwdata[1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .timer_irq (timer_irq)
  );

  // ****************************************
  // One counting step of a unit
  // ****************************************
  // Returns overflow, high byte, low byte
  function automatic logic [16:0] count_step(
    input mode_t      m,
    input logic [7:0] tl,
    input logic [7:0] th,
    input logic       tick
  );
    logic [7:0] l;
    logic [7:0] h;
    logic       o;
    l = tl;
    h = th;
    o = 1'b0;
    if (tick) begin
      case (m)
        MODE_PRESCALED: begin
          // Upper low-byte bits are left alone, only 5 bits prescale
          if (tl[4:0] == PRESCALE_MAX) begin
            l[4:0] = 5'h00;
            o      = (th == BYTE_MAX);
            h      = th + 8'h01;
          end else begin
            l[4:0] = tl[4:0] + 5'h01;
          end
        end
        MODE_CASCADED: begin
          o      = ({th, tl} == {BYTE_MAX, BYTE_MAX});
          {h, l} = {th, tl} + 16'h0001;
        end
        MODE_RELOAD: begin
          if (tl == BYTE_MAX) begin
            l = th;
            o = 1'b1;
          end else begin
            l = tl + 8'h01;
          end
        end
        MODE_SPLIT: begin
          o = (tl == BYTE_MAX);
          l = tl + 8'h01;
        end
        default: begin
          l = tl;
        end
      endcase
    end
    return {o, h, l};
  endfunction

  // ****************************************
  // Mode decode and count enables
  // ****************************************
  assign unit0_pin_gating = s.mode_sel[UNIT0_PIN_GATING];
  assign unit1_pin_gating = s.mode_sel[UNIT1_PIN_GATING];
  assign src0  = s.mode_sel[SRC0];
  assign src1  = s.mode_sel[SRC1];
  assign mode0 = mode_t'(s.mode_sel[MODE0_HI:MODE0_LO]);
  assign mode1 = mode_t'(s.mode_sel[MODE1_HI:MODE1_LO]);
  assign split = (mode0 == MODE_SPLIT);

  // Gate pin is only honoured when the gate bit asks for it
  assign tick0 = s.run0 & (~unit0_pin_gating | pins.irq_level[0])
               & (src0 ? pins.event_fall[0] : 1'b1);

  // In split mode unit 1 loses its run bit to the high byte of unit 0
  assign tick1 = (split | s.run1) & (~unit1_pin_gating | pins.irq_level[1])
               & (src1 ? pins.event_fall[1] : 1'b1)
               & (mode1 != MODE_SPLIT);

  assign tick_h = split & s.run1;
  assign ovf_h  = tick_h & (s.th0 == BYTE_MAX);

  assign step0 = count_step(mode0, s.tl0, s.th0, tick0);
  assign step1 = count_step(mode1, s.tl1, s.th1, tick1);

  assign ovf_set = {split ? ovf_h : step1[16], step0[16]};

  // ****************************************
  // APB decode
  // ****************************************
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = s.rdata;

  always_comb begin
    hit     = 1'b1;
    rd_byte = BYTE_RESET;
    case (paddr)
      ADDR_CONTROL:    rd_byte = {s.ovf1, s.run1, s.ovf0, s.run0, 4'h0};
      ADDR_MODE:       rd_byte = s.mode_sel;
      ADDR_TL0:        rd_byte = s.tl0;
      ADDR_TL1:        rd_byte = s.tl1;
      ADDR_TH0:        rd_byte = s.th0;
      ADDR_TH1:        rd_byte = s.th1;
      ADDR_IRQ_STATUS: rd_byte = {6'h00, irq_status};
      ADDR_IRQ_MASK:   rd_byte = {6'h00, irq_mask};
      default:         hit     = 1'b0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s     = s;
    next_s.tl0 = step0[7:0];
    next_s.th0 = tick_h ? s.th0 + 8'h01 : step0[15:8];
    next_s.tl1 = step1[7:0];
    next_s.th1 = step1[15:8];
    if (setup) begin
      next_s.rdata = {24'h000000, rd_byte};
    end
    // A software write to a count byte wins over the count itself
    if (wr) begin
      case (paddr)
        ADDR_CONTROL: begin
          next_s.ovf1 = pwdata[CTL_OVF1];
          next_s.run1 = pwdata[CTL_RUN1];
          next_s.ovf0 = pwdata[CTL_OVF0];
          next_s.run0 = pwdata[CTL_RUN0];
        end
        ADDR_MODE: next_s.mode_sel = pwdata[7:0];
        ADDR_TL0:  next_s.tl0 = pwdata[7:0];
        ADDR_TL1:  next_s.tl1 = pwdata[7:0];
        ADDR_TH0:  next_s.th0 = pwdata[7:0];
        ADDR_TH1:  next_s.th1 = pwdata[7:0];
        default:   next_s.rdata = s.rdata;
      endcase
    end
    if (unit0_vector_ack) begin
      next_s.ovf0 = 1'b0;
    end
    if (unit1_vector_ack) begin
      next_s.ovf1 = 1'b0;
    end
    // Overflow set wins over any clear in the same cycle
    next_s.ovf0 = next_s.ovf0 | ovf_set[0];
    next_s.ovf1 = next_s.ovf1 | ovf_set[1];
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign unit0_overflow_flag = s.ovf0;
  assign unit1_overflow_flag = s.ovf1;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_unit0_pin_gating_holds_count: assert property (
    unit0_pin_gating && !pins.irq_level[0] && !split && !wr |=> s.tl0 == $past(s.tl0))
    else $error("gated unit 0 advanced with its gate pin low");

  a_unit1_pin_gating_holds_count: assert property (
    unit1_pin_gating && !pins.irq_level[1] && !wr |=> s.tl1 == $past(s.tl1))
    else $error("gated unit 1 advanced with its gate pin low");

  a_timer_counts_clock: assert property (
    s.run0 && !unit0_pin_gating && !src0 && mode0 == MODE_CASCADED && !wr
    |=> {s.th0, s.tl0} == $past({s.th0, s.tl0}) + 16'h0001)
    else $error("unit 0 timer missed a clock cycle");

  a_counter_needs_edge: assert property (
    src0 && !pins.event_fall[0] && !wr |=> s.tl0 == $past(s.tl0))
    else $error("unit 0 counter moved without a pin fall");

  a_cascade_overflow: assert property (
    tick0 && mode0 == MODE_CASCADED && {s.th0, s.tl0} == 16'hFFFF && !wr
    |=> s.ovf0 && s.tl0 == 8'h00 && s.th0 == 8'h00)
    else $error("16-bit wrap did not clear count and set flag");

  a_reload_copy: assert property (
    tick0 && mode0 == MODE_RELOAD && s.tl0 == BYTE_MAX && !wr
    |=> s.tl0 == $past(s.th0) && s.ovf0)
    else $error("auto-reload did not copy the high byte");

  a_prescale_carry: assert property (
    tick0 && mode0 == MODE_PRESCALED && s.tl0[4:0] == PRESCALE_MAX && !wr
    |=> s.tl0[4:0] == 5'h00 && s.th0 == $past(s.th0) + 8'h01)
    else $error("prescaler carry did not step the high byte");

  a_unit1_halted: assert property (
    mode1 == MODE_SPLIT && !wr |=> $stable(s.tl1) && $stable(s.th1))
    else $error("unit 1 counted while halted");

  a_run_stops_unit0: assert property (
    (!s.run0 && !wr) [*2] |-> s.tl0 == $past(s.tl0))
    else $error("unit 0 advanced with its run bit clear");

  a_flag_set_wins: assert property (
    ovf_set[0] && unit0_vector_ack |=> s.ovf0)
    else $error("overflow lost to a same-cycle acknowledge");

  a_ack_clears_flag: assert property (
    unit0_vector_ack && !ovf_set[0] && !wr |=> !s.ovf0)
    else $error("vector acknowledge left unit 0 flag set");

  a_unit1_needs_edge: assert property (
    src1 && !pins.event_fall[1] && !wr |=> s.tl1 == $past(s.tl1))
    else $error("unit 1 counter moved without a pin fall");

  a_split_low_wrap: assert property (
    tick0 && split && s.tl0 == BYTE_MAX && !wr |=> s.tl0 == BYTE_RESET && s.ovf0)
    else $error("split low byte wrap did not set unit 0 flag");

  a_split_high_wrap: assert property (
    split && s.run1 && s.th0 == BYTE_MAX && !wr |=> s.th0 == BYTE_RESET && s.ovf1)
    else $error("split high byte wrap did not set unit 1 flag");

  // Reset leaves both units ungated, clock timed and prescaled
  a_reset_clears_mode: assert property (
    $fell(sys_rst) |-> s.mode_sel == BYTE_RESET)
    else $error("mode fields not cleared by reset");

endmodule
`default_nettype wire

// >>> test/pin_stimulus.sv
// Behavioural model of the external count and gate pins
`timescale 1ns/10ps
`default_nettype none
module pin_stimulus (
  input  wire logic       ref_clk,
  output logic      [1:0] event_pins,
  output logic      [1:0] irq_pins
);
  // ****************************************
  // Pin drive
  // ****************************************
  initial begin
    event_pins = 2'h3;
    irq_pins   = 2'h3;
  end

  // Each level holds two cycles so no sample can miss it
  task automatic pulses(input int u, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      event_pins[u] <= 1'b0;
      repeat (2) @(posedge ref_clk);
      event_pins[u] <= 1'b1;
      @(posedge ref_clk);
    end
  endtask

  task automatic set_irq(input logic [1:0] v);
    @(posedge ref_clk);
    irq_pins <= v;
  endtask
endmodule
`default_nettype wire

// >>> test/dual_timer_mode_control_tb.sv
// Self-checking bench for the dual timer block
`timescale 1ns/10ps
`default_nettype none
module dual_timer_mode_control_tb
  import timer_pkg::*;
;
  // ****************************************
  // Signals and design
  // ****************************************
  logic        ref_clk, sys_rst, psel, penable, pwrite, ack0, ack1, last_err;
  logic [11:0] paddr, atl, ath;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, flag0, flag1, timer_irq;
  logic [1:0]  ev, irq;
  int          error_cnt, tests_run;

  typedef struct {
    logic u; logic [7:0] mode, run, tl, th; int n; logic [1:0] irq; logic [7:0] etl, eth;
    logic [1:0] st;
  } row_t;
  row_t r;
  // Unit 0 split rows stay last: split mode lets unit 1 run on its own
  row_t rows [16] = '{
    '{1'b0, 8'h00, 8'h10, 8'h1E, 8'h05, 3, 2'h3, 8'h01, 8'h06, 2'h0},
    '{1'b0, 8'h00, 8'h10, 8'h1F, 8'hFF, 3, 2'h3, 8'h02, 8'h00, 2'h1},
    '{1'b0, 8'h01, 8'h10, 8'hFE, 8'h12, 3, 2'h3, 8'h01, 8'h13, 2'h0},
    '{1'b0, 8'h01, 8'h10, 8'hFF, 8'hFF, 3, 2'h3, 8'h02, 8'h00, 2'h1},
    '{1'b0, 8'h02, 8'h10, 8'hFE, 8'h80, 4, 2'h3, 8'h82, 8'h80, 2'h1},
    '{1'b0, 8'h05, 8'h10, 8'h10, 8'h00, 4, 2'h3, 8'h10, 8'h00, 2'h0},
    '{1'b0, 8'h09, 8'h10, 8'h10, 8'h00, 4, 2'h2, 8'h10, 8'h00, 2'h0},
    '{1'b0, 8'h09, 8'h10, 8'h10, 8'h00, 4, 2'h3, 8'h14, 8'h00, 2'h0},
    '{1'b1, 8'h00, 8'h40, 8'h1F, 8'h10, 3, 2'h3, 8'h02, 8'h11, 2'h0},
    '{1'b1, 8'h10, 8'h40, 8'hFF, 8'h00, 3, 2'h3, 8'h02, 8'h01, 2'h0},
    '{1'b1, 8'h20, 8'h40, 8'hFF, 8'h33, 3, 2'h3, 8'h35, 8'h33, 2'h2},
    '{1'b1, 8'h30, 8'h40, 8'h10, 8'h20, 4, 2'h3, 8'h10, 8'h20, 2'h0},
    '{1'b1, 8'h50, 8'h40, 8'h10, 8'h00, 4, 2'h3, 8'h10, 8'h00, 2'h0},
    '{1'b1, 8'h90, 8'h40, 8'h10, 8'h00, 4, 2'h1, 8'h10, 8'h00, 2'h0},
    '{1'b0, 8'h03, 8'h40, 8'hFE, 8'hFF, 3, 2'h3, 8'hFE, 8'h02, 2'h2},
    '{1'b0, 8'h03, 8'h10, 8'hFF, 8'h55, 3, 2'h3, 8'h02, 8'h55, 2'h1}};
  logic [11:0] regs [8] = '{ADDR_CONTROL, ADDR_MODE, ADDR_TL0, ADDR_TL1, ADDR_TH0,
                            ADDR_TH1, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};

  dual_timer_mode_control i_dual_timer_mode_control (
    .ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .unit0_event_pin(ev[0]), .unit1_event_pin(ev[1]), .ext_irq0_pin(irq[0]),
    .ext_irq1_pin(irq[1]), .unit0_vector_ack(ack0), .unit1_vector_ack(ack1),
    .unit0_overflow_flag(flag0), .unit1_overflow_flag(flag1), .timer_irq
  );
  pin_stimulus i_pin_stimulus (.ref_clk, .event_pins(ev), .irq_pins(irq));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Every transfer starts with one idle cycle, so run windows are exact
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do @(posedge ref_clk);
    while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(name, q, {24'h0, e});
  endtask

  task automatic results();
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    #500000;
    error_cnt++;
    results();
  end

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ack0 = 1'b0;
    ack1 = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (regs[i]) rd_chk("reset_value", regs[i], 8'h00);
    foreach (rows[i]) begin
      r = rows[i];
      atl = r.u ? ADDR_TL1 : ADDR_TL0;
      ath = r.u ? ADDR_TH1 : ADDR_TH0;
      i_pin_stimulus.set_irq(r.irq);
      apb(1'b1, atl, r.tl);
      apb(1'b1, ath, r.th);
      apb(1'b1, ADDR_MODE, r.mode);
      apb(1'b1, ADDR_CONTROL, r.run);
      // The stop write itself spans three counting edges
      repeat (r.n - 3) @(posedge ref_clk);
      apb(1'b1, ADDR_CONTROL, 8'h00);
      rd_chk("count_low", atl, r.etl);
      rd_chk("count_high", ath, r.eth);
      rd_chk("irq_status", ADDR_IRQ_STATUS, {6'h0, r.st});
      apb(1'b1, ADDR_IRQ_STATUS, 8'h03);
    end
    for (int u = 0; u < 2; u++) begin
      apb(1'b1, ADDR_MODE, u ? 8'h50 : 8'h05);
      apb(1'b1, u ? ADDR_TL1 : ADDR_TL0, 8'h00);
      apb(1'b1, u ? ADDR_CONTROL : ADDR_CONTROL, u ? 8'h40 : 8'h10);
      i_pin_stimulus.pulses(u, 3);
      repeat (6) @(posedge ref_clk);
      apb(1'b1, ADDR_CONTROL, 8'h00);
      rd_chk("event_count", u ? ADDR_TL1 : ADDR_TL0, 8'h03);
    end
    apb(1'b1, ADDR_IRQ_MASK, 8'h02);
    apb(1'b1, ADDR_TL1, 8'hFF);
    apb(1'b1, ADDR_TH1, 8'hFF);
    apb(1'b1, ADDR_MODE, 8'h10);
    apb(1'b1, ADDR_CONTROL, 8'h40);
    apb(1'b1, ADDR_MODE, 8'h30);
    #1 check("flag1_set", {31'h0, flag1}, 32'h1);
    check("irq_raised", {31'h0, timer_irq}, 32'h1);
    rd_chk("control", ADDR_CONTROL, 8'hC0);
    apb(1'b1, ADDR_IRQ_MASK, 8'h00);
    #1 check("irq_masked", {31'h0, timer_irq}, 32'h0);
    apb(1'b1, ADDR_IRQ_MASK, 8'h02);
    @(posedge ref_clk);
    ack0 <= 1'b1;
    ack1 <= 1'b1;
    @(posedge ref_clk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    #1 check("flag1_acked", {31'h0, flag1}, 32'h0);
    apb(1'b1, ADDR_IRQ_STATUS, 8'h02);
    #1 check("irq_cleared", {31'h0, timer_irq}, 32'h0);
    // Wrap and acknowledge meet on one edge: the wrap must win
    apb(1'b1, ADDR_TL0, 8'hFF);
    apb(1'b1, ADDR_TH0, 8'hFF);
    apb(1'b1, ADDR_MODE, 8'h01);
    apb(1'b1, ADDR_CONTROL, 8'h10);
    ack0 <= 1'b1;
    @(posedge ref_clk);
    ack0 <= 1'b0;
    #1 check("flag0_set_wins", {31'h0, flag0}, 32'h1);
    rd_chk("unmapped", 12'h300, 8'h00);
    check("unmapped_err", {31'h0, last_err}, 32'h1);
    apb(1'b1, ADDR_MODE, 8'hFF);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk("mode_after_reset", ADDR_MODE, 8'h00);
    results();
  end
endmodule
`default_nettype wire
